// >>> hw/sbccfg_pkg.sv
// sbccfg_pkg: frame layout, bank selects, field layouts and reset values
// of the configuration and diagnosis register set.
// assumes 16-bit spi frames, sent and received least significant bit first.
package sbccfg_pkg;

  // frame layout
  localparam int FRAME_W = 16;
  localparam int CNT_W = 5;
  localparam int MODE_LSB = 0;
  localparam int SEL_LSB = 3;
  localparam int DATA_LSB = 6;
  localparam int DATA_W = 9;
  localparam int PARITY_POS = 14;
  localparam int PARITY_HI = 13;
  localparam int PARITY_LO = 6;

  // command and bank select codes
  localparam logic [2:0] CMD_READ_ONLY = 3'h7;
  localparam logic [2:0] SEL_SYSCONF = 3'h4;
  localparam logic [2:0] SEL_COMM = 3'h5;
  localparam logic [2:0] SEL_WDOG = 3'h6;
  localparam logic [2:0] SEL_DIAG = 3'h7;
  localparam logic [2:0] SEL_RESET = 3'h4;

  // reset threshold codes
  localparam logic [1:0] RT_INVALID = 2'h0;
  localparam logic [1:0] RT_LEVEL_ONE = 2'h1;
  localparam logic [1:0] RT_LEVEL_TWO = 2'h2;
  localparam logic [1:0] RT_LEVEL_THREE = 2'h3;

  // restart cause codes
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_UNDERVOLT = 2'h1;
  localparam logic [1:0] CAUSE_WDOG_WAKE = 2'h2;
  localparam logic [1:0] CAUSE_FLASH_EXT = 2'h3;

  // watchdog period encoding
  localparam logic [4:0] WD_SPLIT_CODE = 5'h10;
  localparam logic [10:0] WD_SHORT_STEP_MS = 11'h010;
  localparam logic [10:0] WD_LONG_STEP_MS = 11'h030;
  localparam logic [10:0] WD_LONG_OFFSET_MS = 11'h1d0;

  // time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // cell modes, shared by can and lin
  typedef enum logic [1:0] {
    SBCCFG_CELL_OFF = 2'b00,
    SBCCFG_CELL_WAKE = 2'b01,
    SBCCFG_CELL_RX_ONLY = 2'b10,
    SBCCFG_CELL_NORMAL = 2'b11
  } sbccfg_cell_mode_t;

  // system configuration bank, lsb is frame bit 6
  typedef struct packed {
    logic watchdog_failure_policy;
    logic cyclic_wake_en;
    logic fallback_output_enable;
    logic vcc2_en;
    logic wake_pin_en;
    logic vcc3_en;
    logic long_reset_delay;
    logic [1:0] reset_threshold_select;
  } sbccfg_sys_t;

  // communication setup bank
  typedef struct packed {
    sbccfg_cell_mode_t lin_cell_mode;
    sbccfg_cell_mode_t can_cell_mode;
    logic slow_slope_select;
  } sbccfg_comm_t;

  // watchdog bank, write_parity_bit sits above it in the frame
  typedef struct packed {
    logic enable;
    logic reserved_one;
    logic supervision_type_select;
    logic [4:0] period_code;
  } sbccfg_wdog_t;

  // diagnosis bank, read only
  typedef struct packed {
    logic [2:0] test_cfg;
    logic [2:0] limp_cause;
    logic restart_cause_hi;
    logic restart_cause_lo;
  } sbccfg_diag_t;

  localparam sbccfg_sys_t SYS_RESET = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
                                        1'b0, 1'b1, RT_LEVEL_ONE};
  localparam sbccfg_comm_t COMM_RESET = '{SBCCFG_CELL_OFF, SBCCFG_CELL_OFF,
                                          1'b1};
  localparam sbccfg_wdog_t WDOG_RESET = '{1'b1, 1'b1, 1'b1, 5'h0f};

endpackage

// >>> hw/sbccfg_regs.sv
// sbccfg_regs: spi-reached configuration and diagnosis registers with
// reset threshold decode, wake pin gating and watchdog period timer.
// assumes spi mode 0, lsb first, 16-bit frames; event inputs are
// one-cycle pulses from logic on sys_clk.
`timescale 1ns/1ps

module sbccfg_regs
  import sbccfg_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic wake_input,
  input wire logic limp_entry,
  input wire logic [2:0] limp_cause,
  input wire logic [2:0] test_cfg,
  input wire logic undervolt_evt,
  input wire logic flash_ext_reset_evt,
  input wire logic cyclic_noack_evt,
  input wire logic restart_from_sleep,
  output sbccfg_sys_t sys_cfg,
  output sbccfg_comm_t comm_cfg,
  output sbccfg_wdog_t wd_cfg,
  output logic threshold_level_one,
  output logic threshold_level_two,
  output logic threshold_level_three,
  output logic wake_req,
  output logic [10:0] wd_period_ms,
  output logic wd_expired
);

  localparam int TICK_W = $clog2(TICK_CYC + 1);

  // link side state
  logic [CNT_W-1:0] bit_cnt_q; // bits taken in this frame
  logic [FRAME_W-1:0] rx_q; // shift in, reset per frame
  logic [FRAME_W-1:0] frame_q; // last complete frame
  logic frame_tog_q; // flips once per complete frame
  logic sdo_q; // output bit, launched on falling edge
  logic [FRAME_W-1:0] tx_word; // answer word for this frame
  logic [2:0] tx_sel; // bank whose data is sent
  logic [DATA_W-1:0] tx_data; // data bits of that bank

  // system side state
  logic cs_s1_q, cs_s2_q; // chip select synchroniser
  logic tog_s1_q, tog_s2_q, tog_s3_q; // frame event synchroniser
  logic wk_s1_q, wk_s2_q, wk_s3_q; // wake pin synchroniser
  logic frame_evt; // one cycle per received frame
  logic [2:0] f_mode; // command field of that frame
  logic [2:0] f_sel; // bank select of that frame
  logic f_ro; // read-only command
  logic f_wr; // anything else writes
  logic parity_ok; // watchdog write parity holds
  sbccfg_sys_t sys_q;
  sbccfg_sys_t sys_wr; // incoming system word
  sbccfg_comm_t comm_q;
  sbccfg_wdog_t wdog_q;
  sbccfg_wdog_t wdog_wr; // incoming watchdog word
  logic [1:0] cause_q; // restart cause
  logic [2:0] prev_sel_q; // bank answered in the next frame
  logic [3:0][DATA_W-1:0] snap_q; // banks 100..111, frozen per frame
  logic [2:0] snap_prev_q; // prev_sel frozen per frame
  logic [TICK_W-1:0] tick_cnt_q; // ms prescaler
  logic tick; // one cycle per ms
  logic [10:0] wd_ms_q; // ms since last service
  logic wd_fail; // period ran out
  logic fail_once_q; // one failure already seen
  logic limp_set; // fallback entry this cycle
  logic [10:0] period_ext; // code zero-extended

  // serial input, counter and data reset by chip select high
  always_ff @(posedge spi_sclk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      bit_cnt_q <= '0;
      rx_q <= '0;
    end
    else if (bit_cnt_q < CNT_W'(FRAME_W))
    begin
      rx_q[bit_cnt_q[3:0]] <= spi_sdi;
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // complete frame capture; short frames never flip the toggle
  always_ff @(posedge spi_sclk or posedge rst)
  begin
    if (rst)
    begin
      frame_q <= '0;
      frame_tog_q <= 1'b0;
    end
    else if (!spi_cs_n && bit_cnt_q == CNT_W'(FRAME_W - 1))
    begin
      frame_q <= {spi_sdi, rx_q[FRAME_W-2:0]};
      frame_tog_q <= ~frame_tog_q;
    end
  end

  // answer source: read-only picks the bank named in this frame, the
  // select bits arrive before the first data bit goes out
  always_comb
  begin
    tx_sel = snap_prev_q;
    if (rx_q[MODE_LSB+:3] == CMD_READ_ONLY)
    begin
      tx_sel = rx_q[SEL_LSB+:3];
    end
    tx_data = '0; // banks 000..011 answer zero here
    if (tx_sel[2])
    begin
      tx_data = snap_q[tx_sel[1:0]];
    end
    tx_word = {1'b0, tx_data, snap_prev_q, 3'h0};
  end

  // serial output, next bit launched on the falling edge
  always_ff @(negedge spi_sclk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      sdo_q <= 1'b0;
    end
    else if (bit_cnt_q < CNT_W'(FRAME_W))
    begin
      sdo_q <= tx_word[bit_cnt_q[3:0]];
    end
  end

  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = ~spi_cs_n;

  // chip select level into sys_clk
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end
    else
    begin
      cs_s1_q <= spi_cs_n;
      cs_s2_q <= cs_s1_q;
    end
  end

  // frame toggle into sys_clk, third stage for the edge
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end
    else
    begin
      tog_s1_q <= frame_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // wake pin into sys_clk
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wk_s1_q <= 1'b0;
      wk_s2_q <= 1'b0;
      wk_s3_q <= 1'b0;
    end
    else
    begin
      wk_s1_q <= wake_input;
      wk_s2_q <= wk_s1_q;
      wk_s3_q <= wk_s2_q;
    end
  end

  // any edge on the pin wakes only while enabled
  assign wake_req = (wk_s2_q ^ wk_s3_q) & sys_q.wake_pin_en;

  // frame decode; frame_q is stable for a whole frame after the toggle
  assign frame_evt = tog_s2_q ^ tog_s3_q;
  assign f_mode = frame_q[MODE_LSB+:3];
  assign f_sel = frame_q[SEL_LSB+:3];
  assign f_ro = frame_evt && f_mode == CMD_READ_ONLY;
  assign f_wr = frame_evt && f_mode != CMD_READ_ONLY;
  assign sys_wr = frame_q[DATA_LSB+:DATA_W];
  assign comm_cfg = comm_q;
  assign wdog_wr = frame_q[DATA_LSB+:8];
  assign parity_ok = (^frame_q[PARITY_HI:PARITY_LO]) ==
                     frame_q[PARITY_POS];

  // fallback entry: outside request or watchdog per policy
  assign limp_set = limp_entry ||
    (wd_fail && (!sys_q.watchdog_failure_policy || fail_once_q));

  // system configuration bank
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sys_q <= SYS_RESET;
    end
    else
    begin
      if (f_wr && f_sel == SEL_SYSCONF)
      begin
        sys_q <= sys_wr;
        if (sys_wr.reset_threshold_select == RT_INVALID)
        begin
          // invalid code leaves the old threshold in place
          sys_q.reset_threshold_select <=
            sys_q.reset_threshold_select;
        end
      end
      // entry wins over a clearing write in the same cycle
      if (limp_set)
      begin
        sys_q.fallback_output_enable <= 1'b1;
      end
    end
  end

  assign sys_cfg = sys_q;

  // threshold level decode
  assign threshold_level_one =
    sys_q.reset_threshold_select == RT_LEVEL_ONE;
  assign threshold_level_two =
    sys_q.reset_threshold_select == RT_LEVEL_TWO;
  assign threshold_level_three =
    sys_q.reset_threshold_select == RT_LEVEL_THREE;

  // communication setup bank
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      comm_q <= COMM_RESET;
    end
    else if (f_wr && f_sel == SEL_COMM)
    begin
      comm_q <= sbccfg_comm_t'(frame_q[DATA_LSB+:5]);
    end
  end

  // watchdog bank; a bad parity write is dropped whole
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wdog_q <= WDOG_RESET;
    end
    else if (f_wr && f_sel == SEL_WDOG && parity_ok)
    begin
      wdog_q <= wdog_wr;
      wdog_q.reserved_one <= 1'b1;
    end
  end

  assign wd_cfg = wdog_q;

  // period decode, two linear segments
  assign period_ext = {6'h00, wdog_q.period_code};
  always_comb
  begin
    if (wdog_q.period_code < WD_SPLIT_CODE)
    begin
      wd_period_ms = (period_ext + 11'h001) * WD_SHORT_STEP_MS;
    end
    else
    begin
      wd_period_ms = period_ext * WD_LONG_STEP_MS -
                     WD_LONG_OFFSET_MS;
    end
  end

  // millisecond prescaler
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_q <= '0;
    end
    else if (tick)
    begin
      tick_cnt_q <= '0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  assign tick = tick_cnt_q == TICK_W'(TICK_CYC - 1);

  // watchdog timer; any complete frame services it, window mode is
  // supervised as a timeout, the open window is not checked here
  assign wd_fail = wdog_q.enable && tick &&
                   wd_ms_q >= wd_period_ms - 11'h001;
  assign wd_expired = wd_fail;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wd_ms_q <= '0;
    end
    else if (frame_evt || wd_fail || !wdog_q.enable)
    begin
      wd_ms_q <= '0;
    end
    else if (tick)
    begin
      wd_ms_q <= wd_ms_q + 11'h001;
    end
  end

  // consecutive failure memory, a service breaks the chain
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fail_once_q <= 1'b0;
    end
    else if (wd_fail)
    begin
      fail_once_q <= ~fail_once_q;
    end
    else if (frame_evt)
    begin
      fail_once_q <= 1'b0;
    end
  end

  // restart cause; a new cause wins over a diag read or sleep clear, fallback entry clears over all
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cause_q <= CAUSE_NONE;
    end
    else if (limp_set)
    begin
      cause_q <= CAUSE_NONE;
    end
    else if (flash_ext_reset_evt)
    begin
      cause_q <= CAUSE_FLASH_EXT;
    end
    else if (wd_fail || cyclic_noack_evt)
    begin
      cause_q <= CAUSE_WDOG_WAKE;
    end
    else if (undervolt_evt)
    begin
      cause_q <= CAUSE_UNDERVOLT;
    end
    else if ((f_ro && f_sel == SEL_DIAG) || restart_from_sleep)
    begin
      cause_q <= CAUSE_NONE;
    end
  end

  // bank to answer in the following frame
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prev_sel_q <= SEL_SYSCONF;
    end
    else if (f_wr)
    begin
      prev_sel_q <= f_sel;
    end
  end

  // snapshot for the link, only refreshed while chip select is high so
  // the link side never sees it move inside a frame
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      snap_q <= '0;
      snap_prev_q <= SEL_SYSCONF;
    end
    else if (cs_s2_q)
    begin
      snap_q[0] <= sys_q;
      snap_q[1] <= {4'h0, comm_q};
      snap_q[2] <= {^wdog_q, wdog_q}; // parity shown as held
      snap_q[3] <= {1'b0, test_cfg, limp_cause, cause_q};
      snap_prev_q <= prev_sel_q;
    end
  end

endmodule

// >>> tb/sbccfg_regs_monitor.sv
// sbccfg_regs_monitor: port checks of the register block.
// assumes one sys_clk domain, rst active high; bound at the foot.
`timescale 1ns/1ps

module sbccfg_regs_monitor
  import sbccfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic wake_req,
  input wire logic limp_entry,
  input wire logic wd_expired,
  input wire sbccfg_sys_t sys_cfg,
  input wire sbccfg_comm_t comm_cfg,
  input wire sbccfg_wdog_t wd_cfg,
  input wire logic threshold_level_one,
  input wire logic threshold_level_two,
  input wire logic threshold_level_three,
  input wire logic [10:0] wd_period_ms
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic [10:0] per_exp; // period from code, two linear pieces
  // short codes step 16 ms, long codes step 48 ms
  always_comb
  begin
    if (wd_cfg.period_code < 5'h10)
      per_exp = ({6'h00, wd_cfg.period_code} + 11'h001) * 11'h010;
    else
      per_exp = {6'h00, wd_cfg.period_code} * 11'h030 - 11'h1d0;
  end

  // decodes follow the field in the same cycle; checked once the field has settled
  sequence s_thr_held;
    $stable(sys_cfg.reset_threshold_select) [*2];
  endsequence
  sequence s_code_held;
    $stable(wd_cfg.period_code) [*2];
  endsequence
  sequence s_one_fail;
    wd_expired && !sys_cfg.watchdog_failure_policy;
  endsequence

  thr_decode_a: assert property (
    s_thr_held |-> threshold_level_one == (sys_cfg[1:0] == 2'h1)
    && threshold_level_two == (sys_cfg[1:0] == 2'h2)
    && threshold_level_three == (sys_cfg[1:0] == 2'h3))
    else $error("threshold decode wrong");
  thr_valid_a: assert property (
    sys_cfg.reset_threshold_select != 2'h0)
    else $error("threshold code zero held");
  resv_one_a: assert property (wd_cfg.reserved_one)
    else $error("reserved watchdog bit not one");
  period_map_a: assert property (
    s_code_held |-> wd_period_ms == per_exp)
    else $error("watchdog period decode wrong");
  wake_gate_a: assert property (
    wake_req |-> sys_cfg.wake_pin_en || $past(sys_cfg.wake_pin_en))
    else $error("wake while pin disabled");
  limp_set_a: assert property (
    limp_entry |-> ##[1:4] sys_cfg.fallback_output_enable)
    else $error("fallback not set on entry");
  one_fail_a: assert property (
    s_one_fail |-> ##[1:4] sys_cfg.fallback_output_enable)
    else $error("single failure left fallback off");
  wd_off_a: assert property (
    !wd_cfg.enable [*2] |-> !wd_expired)
    else $error("expiry while watchdog off");
  cfg_hold_a: assert property (
    spi_cs_n [*8] |-> $stable(comm_cfg) && $stable(wd_cfg))
    else $error("config moved without a frame");
  sdo_oe_a: assert property (spi_sdo_oe == !spi_cs_n)
    else $error("output enable not tied to select");
endmodule

bind sbccfg_regs sbccfg_regs_monitor i_sbccfg_regs_monitor (
  .sys_clk, .rst, .spi_cs_n, .spi_sdo_oe, .wake_req, .limp_entry,
  .wd_expired, .sys_cfg, .comm_cfg, .wd_cfg, .threshold_level_one,
  .threshold_level_two, .threshold_level_three, .wd_period_ms
);

// >>> tb/sbccfg_host.sv
// sbccfg_host: spi master model, mode 0, 16-bit frames lsb first.
// assumes the device answers on spi_sdo while spi_cs_n is low.
`timescale 1ns/1ps

module sbccfg_host
(
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  // idle: clock stands still low, device deselected
  initial
  begin
    // non-blocking so the deselect edge resets the link logic
    spi_sclk <= 1'b0;
    spi_cs_n <= 1'b1;
    spi_sdi <= 1'b0;
  end

  // one whole frame at an 80 ns link period, odd phase to sys_clk
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #7;
    spi_cs_n = 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      spi_sdi = tx[k];
      #40;
      spi_sclk = 1'b1;
      rx[k] = spi_sdo; // taken at the rising edge, stable since fall
      #40;
      spi_sclk = 1'b0;
    end
    #40;
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi; // released line never shows the last bit
    #200; // gap of five sys_clk periods
  endtask
endmodule

// >>> tb/sbccfg_regs_test.sv
// sbccfg_regs_test: directed scenarios for the register block.
// assumes sbccfg_host on the link and the bound port monitor.
`timescale 1ns/1ps

module sbccfg_regs_test
  import sbccfg_pkg::*;
;
  logic sys_clk, rst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic wake_input, limp_entry, undervolt_evt, flash_ext_reset_evt;
  logic cyclic_noack_evt, restart_from_sleep, wake_req, wd_expired;
  logic threshold_level_one, threshold_level_two, threshold_level_three;
  logic [2:0] limp_cause, test_cfg;
  logic [10:0] wd_period_ms;
  logic [15:0] rx; // last answer word
  sbccfg_sys_t sys_cfg;
  sbccfg_comm_t comm_cfg;
  sbccfg_wdog_t wd_cfg;
  int err_count;
  int checks;

  // 25 mhz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  sbccfg_regs #(.TICK_CYC(4)) i_sbccfg_regs (
    .sys_clk, .rst, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
    .spi_sdo_oe, .wake_input, .limp_entry, .limp_cause, .test_cfg,
    .undervolt_evt, .flash_ext_reset_evt, .cyclic_noack_evt,
    .restart_from_sleep, .sys_cfg, .comm_cfg, .wd_cfg,
    .threshold_level_one, .threshold_level_two, .threshold_level_three,
    .wake_req, .wd_period_ms, .wd_expired
  );
  sbccfg_host i_sbccfg_host (.spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // write frame, then let the sys_clk side act on it
  task automatic wr(input logic [2:0] sel, input logic [8:0] d);
    i_sbccfg_host.xfer({1'b0, d, sel, 3'h0}, rx);
    repeat (6) @(posedge sys_clk);
  endtask

  // read-only frame: data of this select in this same frame
  task automatic ro(input logic [2:0] sel, input logic [8:0] exp);
    i_sbccfg_host.xfer({1'b0, 9'h000, sel, CMD_READ_ONLY}, rx);
    chk(rx[14:6], exp);
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic t_defaults();
    chk(sys_cfg, 16'h0115);
    chk(comm_cfg, 16'h0001);
    chk(wd_cfg, 16'h00ef);
    chk({threshold_level_three, threshold_level_two,
         threshold_level_one}, 16'h0001);
    ro(SEL_SYSCONF, 9'h115);
    ro(SEL_COMM, 9'h001);
    ro(SEL_WDOG, 9'h1ef);
    $display("t_defaults done");
  endtask

  task automatic t_wdog();
    logic [4:0] code [4] = '{5'h00, 5'h0f, 5'h10, 5'h1f};
    logic [10:0] ms [4] = '{11'h010, 11'h100, 11'h130, 11'h400};
    logic [7:0] d8;
    int n;
    for (int i = 0; i < 4; i++)
    begin
      d8 = {3'b111, code[i]}; // reserved bit kept at one
      wr(SEL_WDOG, {^d8, d8});
      chk(wd_period_ms, ms[i]);
    end
    d8 = 8'h65;
    wr(SEL_WDOG, {~^d8, d8}); // wrong parity
    chk(wd_cfg, 16'h00ff);
    chk(wd_period_ms, 11'h400);
    wr(SEL_WDOG, 9'h140); // off, window type
    chk(wd_cfg, 16'h0040);
    ro(SEL_WDOG, 9'h140);
    n = 0;
    repeat (300) @(posedge sys_clk) if (wd_expired === 1'b1) n++;
    chk(16'(n), 16'h0000);
    $display("t_wdog done");
  endtask

  task automatic t_sys();
    wr(SEL_SYSCONF, 9'h096); // policy 0, cyclic on, threshold 10
    chk(sys_cfg, 16'h0096);
    chk({threshold_level_three, threshold_level_two,
         threshold_level_one}, 16'h0002);
    wr(SEL_SYSCONF, 9'h09c); // code 00 with vcc3 on
    chk(rx[14:6], 9'h096);
    chk(sys_cfg, 16'h009e);
    wr(SEL_SYSCONF, 9'h09f);
    chk({threshold_level_three, threshold_level_two,
         threshold_level_one}, 16'h0004);
    ro(SEL_SYSCONF, 9'h09f);
    $display("t_sys done");
  endtask

  task automatic t_comm();
    logic [1:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      wr(SEL_COMM, {4'h0, m, ~m, m[0]});
      chk(comm_cfg, {m, ~m, m[0]});
    end
    ro(SEL_COMM, 9'h019);
    $display("t_comm done");
  endtask

  task automatic t_diag();
    wr(SEL_DIAG, 9'h1ff);
    wr(3'h0, 9'h000); // unmapped bank
    chk(sys_cfg, 16'h009f);
    chk(comm_cfg, 16'h0019);
    for (int i = 1; i < 4; i++)
    begin
      @(posedge sys_clk);
      undervolt_evt <= (i == 1);
      cyclic_noack_evt <= (i == 2);
      flash_ext_reset_evt <= (i == 3);
      @(posedge sys_clk);
      {undervolt_evt, cyclic_noack_evt, flash_ext_reset_evt} <= 3'h0;
      repeat (4) @(posedge sys_clk);
      ro(SEL_DIAG, {3'h6, 3'h5, i[1:0]});
      ro(SEL_DIAG, 9'h0d4);
    end
    @(posedge sys_clk) undervolt_evt <= 1'b1;
    @(posedge sys_clk) undervolt_evt <= 1'b0;
    repeat (3) @(posedge sys_clk) restart_from_sleep <= 1'b1;
    @(posedge sys_clk) restart_from_sleep <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ro(SEL_DIAG, 9'h0d4);
    $display("t_diag done");
  endtask

  task automatic t_wake();
    int n;
    for (int i = 0; i < 2; i++)
    begin
      n = 0;
      @(posedge sys_clk) wake_input <= ~wake_input;
      repeat (10) @(posedge sys_clk) if (wake_req === 1'b1) n++;
      chk(16'(n), 16'(1 - i));
      wr(SEL_SYSCONF, 9'h08f); // wake pin off
    end
    $display("t_wake done");
  endtask

  task automatic t_limp();
    int n;
    @(posedge sys_clk) limp_entry <= 1'b1;
    @(posedge sys_clk) limp_entry <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk(sys_cfg.fallback_output_enable, 1'b1);
    wr(SEL_SYSCONF, 9'h08f);
    chk(sys_cfg.fallback_output_enable, 1'b0);
    wr(SEL_WDOG, 9'h0c0); // on, 16 ms, policy 0 held
    n = 0;
    while (wd_expired !== 1'b1 && n < 300) @(posedge sys_clk) n++;
    chk(n > 40 && n < 80, 1'b1);
    repeat (5) @(posedge sys_clk);
    chk(sys_cfg.fallback_output_enable, 1'b1);
    // policy 1: first failure leaves fallback off, second sets it
    wr(SEL_SYSCONF, 9'h10f);
    for (int i = 0; i < 2; i++)
    begin
      n = 0;
      while (wd_expired !== 1'b1 && n < 300) @(posedge sys_clk) n++;
      repeat (5) @(posedge sys_clk);
      chk(sys_cfg.fallback_output_enable, i[0]);
    end
    $display("t_limp done");
  endtask

  task automatic conclude();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial
  begin
    // non-blocking so the reset edge reaches every waiting process
    {rst, wake_input, limp_entry, undervolt_evt} <= 4'h8;
    {flash_ext_reset_evt, cyclic_noack_evt, restart_from_sleep} = 3'h0;
    limp_cause = 3'h5;
    test_cfg = 3'h6;
    err_count = 0;
    checks = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_defaults();
    t_wdog();
    t_sys();
    t_comm();
    t_diag();
    t_wake();
    t_limp();
    conclude();
  end

  // hang guard, several times the expected run
  initial
  begin
    #400000;
    err_count++;
    conclude();
  end
endmodule
